// *** hdl/tcsirq_channel.sv ***
// Notes on behaviour
// - An external trigger sets a sticky flag that a status read clears.
// - A status bit shows whether the counter clock is on, and a read leaves it alone.
// - A status bit mirrors line A: pin level in capture mode, driven level in waveform mode.
// - A status bit mirrors line B: pin level in capture mode, driven level in waveform mode.
// - Writing ones to the enable register sets those mask bits; zeros change nothing.
// - Writing ones to the disable register clears those mask bits; zeros change nothing.
// - The mask view register reads back the current mask.
// - Disable bits for overrun and the two loads act only in capture mode.
// - Disable bits for compares A and B act only in waveform mode.
// - A counter overflow sets a sticky flag until the next status read.
// - In capture mode a second unread load of A or B sets the overrun flag.
// - A compare C match sets a sticky flag in either mode until the next status read.
//
// Local design decisions: strobed register access and the register addresses.
module tcsirq_channel
  import tcsirq_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic [TCSIRQ_ADDR_W-1:0] addr_in,
  input  wire logic [TCSIRQ_DATA_W-1:0] wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic      [TCSIRQ_DATA_W-1:0] rdata_out,
  input  wire logic                     wave_mode_in,
  input  wire logic                     overflow_evt_in,
  input  wire logic                     compare_a_evt_in,
  input  wire logic                     compare_b_evt_in,
  input  wire logic                     compare_c_evt_in,
  input  wire logic                     load_a_evt_in,
  input  wire logic                     load_b_evt_in,
  input  wire logic                     capture_a_read_in,
  input  wire logic                     capture_b_read_in,
  input  wire logic                     ext_trigger_evt_in,
  input  wire logic                     counter_clock_on_in,
  input  wire logic                     timer_line_a_pin_in,
  input  wire logic                     timer_line_a_drive_in,
  input  wire logic                     timer_line_b_pin_in,
  input  wire logic                     timer_line_b_drive_in,
  output logic                          irq_out
);
  logic [TCSIRQ_NUM_SRC-1:0] flags;
  logic [TCSIRQ_NUM_SRC-1:0] next_flags;
  logic [TCSIRQ_NUM_SRC-1:0] set_vec;
  logic [TCSIRQ_NUM_SRC-1:0] mask;
  logic [TCSIRQ_NUM_SRC-1:0] next_mask;
  logic [TCSIRQ_NUM_SRC-1:0] clear_allow;
  logic [TCSIRQ_DATA_W-1:0]  rdata;
  logic [TCSIRQ_DATA_W-1:0]  next_rdata;
  logic                      irq;
  logic                      next_irq;
  logic                      status_rd;
  logic                      overrun_evt;
  logic                      capture_mode;
  logic                      line_a_level;
  logic                      line_b_level;

  assign capture_mode = ~wave_mode_in;
  assign status_rd    = rd_in && (addr_in == TCSIRQ_OFF_STATUS);

  tcsirq_overrun_detect u_overrun (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .capture_mode_in (capture_mode),
    .load_a_in       (load_a_evt_in),
    .load_b_in       (load_b_evt_in),
    .read_a_in       (capture_a_read_in),
    .read_b_in       (capture_b_read_in),
    .overrun_out     (overrun_evt)
  );

  // Event vector, gated by the mode in which each source exists
  always_comb begin
    set_vec                       = '0;
    set_vec[TCSIRQ_BIT_OVERFLOW]  = overflow_evt_in;
    set_vec[TCSIRQ_BIT_OVERRUN]   = overrun_evt;
    set_vec[TCSIRQ_BIT_CMP_A]     = compare_a_evt_in & wave_mode_in;
    set_vec[TCSIRQ_BIT_CMP_B]     = compare_b_evt_in & wave_mode_in;
    set_vec[TCSIRQ_BIT_CMP_C]     = compare_c_evt_in;
    set_vec[TCSIRQ_BIT_LOAD_A]    = load_a_evt_in & capture_mode;
    set_vec[TCSIRQ_BIT_LOAD_B]    = load_b_evt_in & capture_mode;
    set_vec[TCSIRQ_BIT_EXT_TRIG]  = ext_trigger_evt_in;
  end

  tcsirq_sticky_flags u_flags (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .set_in         (set_vec),
    .clear_in       (status_rd),
    .flags_out      (flags),
    .next_flags_out (next_flags)
  );

  // Mirrors follow pin in capture mode, driven level in waveform mode
  assign line_a_level = wave_mode_in ? timer_line_a_drive_in : timer_line_a_pin_in;
  assign line_b_level = wave_mode_in ? timer_line_b_drive_in : timer_line_b_pin_in;

  // Mode-qualified disable
  always_comb begin
    clear_allow = ~(TCSIRQ_CAPTURE_ONLY | TCSIRQ_WAVE_ONLY);
    if (capture_mode) begin
      clear_allow = clear_allow | TCSIRQ_CAPTURE_ONLY;
    end else begin
      clear_allow = clear_allow | TCSIRQ_WAVE_ONLY;
    end
  end

  always_comb begin
    next_mask = mask;
    if (wr_in && (addr_in == TCSIRQ_OFF_EN_SET)) begin
      next_mask = mask | wdata_in[TCSIRQ_NUM_SRC-1:0];
    end else if (wr_in && (addr_in == TCSIRQ_OFF_EN_CLEAR)) begin
      next_mask = mask & ~(wdata_in[TCSIRQ_NUM_SRC-1:0] & clear_allow);
    end
  end

  // Read data; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = '0;
    if (rd_in) begin
      unique case (addr_in)
        TCSIRQ_OFF_STATUS: begin
          next_rdata[TCSIRQ_NUM_SRC-1:0] = flags;
          next_rdata[TCSIRQ_BIT_CLK_ON]  = counter_clock_on_in;
          next_rdata[TCSIRQ_BIT_LINE_A]  = line_a_level;
          next_rdata[TCSIRQ_BIT_LINE_B]  = line_b_level;
        end
        TCSIRQ_OFF_MASK_VIEW: begin
          next_rdata[TCSIRQ_NUM_SRC-1:0] = mask;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Registered so the output tracks the flags and mask in the same cycle
  always_comb begin
    next_irq = |(next_flags & next_mask);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask  <= TCSIRQ_MASK_RESET;
      rdata <= TCSIRQ_RDATA_RESET;
      irq   <= 1'b0;
    end else begin
      mask  <= next_mask;
      rdata <= next_rdata;
      irq   <= next_irq;
    end
  end

  assign rdata_out = rdata;
  assign irq_out   = irq;
endmodule

// *** hdl/tcsirq_overrun_detect.sv ***
module tcsirq_overrun_detect
  import tcsirq_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic capture_mode_in,
  input  wire logic load_a_in,
  input  wire logic load_b_in,
  input  wire logic read_a_in,
  input  wire logic read_b_in,
  output logic      overrun_out
);
  logic pend_a;
  logic pend_b;
  logic next_pend_a;
  logic next_pend_b;

  // Pending: loaded and not yet read back
  always_comb begin
    next_pend_a = pend_a;
    next_pend_b = pend_b;
    if (!capture_mode_in) begin
      next_pend_a = 1'b0;
      next_pend_b = 1'b0;
    end else begin
      if (read_a_in) begin
        next_pend_a = 1'b0;
      end
      if (read_b_in) begin
        next_pend_b = 1'b0;
      end
      if (load_a_in) begin
        next_pend_a = 1'b1;
      end
      if (load_b_in) begin
        next_pend_b = 1'b1;
      end
    end
    // A load on top of an unread earlier load
    overrun_out = capture_mode_in &
                  ((load_a_in & pend_a & ~read_a_in) |
                   (load_b_in & pend_b & ~read_b_in));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else begin
      pend_a <= next_pend_a;
      pend_b <= next_pend_b;
    end
  end
endmodule

// *** hdl/tcsirq_pkg.sv ***
package tcsirq_pkg;
  localparam int          TCSIRQ_NUM_SRC       = 8;
  localparam int          TCSIRQ_ADDR_W        = 8;
  localparam int          TCSIRQ_DATA_W        = 32;
  // Register byte offsets
  localparam logic [7:0]  TCSIRQ_OFF_STATUS    = 8'h00;
  localparam logic [7:0]  TCSIRQ_OFF_EN_SET    = 8'h04;
  localparam logic [7:0]  TCSIRQ_OFF_EN_CLEAR  = 8'h08;
  localparam logic [7:0]  TCSIRQ_OFF_MASK_VIEW = 8'h0c;
  // Bit positions: sources 0-7 shared by status, enable, disable and mask; 16-18 in status only
  localparam int          TCSIRQ_BIT_OVERFLOW  = 0;
  localparam int          TCSIRQ_BIT_OVERRUN   = 1;
  localparam int          TCSIRQ_BIT_CMP_A     = 2;
  localparam int          TCSIRQ_BIT_CMP_B     = 3;
  localparam int          TCSIRQ_BIT_CMP_C     = 4;
  localparam int          TCSIRQ_BIT_LOAD_A    = 5;
  localparam int          TCSIRQ_BIT_LOAD_B    = 6;
  localparam int          TCSIRQ_BIT_EXT_TRIG  = 7;
  localparam int          TCSIRQ_BIT_CLK_ON    = 16;
  localparam int          TCSIRQ_BIT_LINE_A    = 17;
  localparam int          TCSIRQ_BIT_LINE_B    = 18;
  // Sources that exist only in capture mode, and only in waveform mode
  localparam logic [7:0]  TCSIRQ_CAPTURE_ONLY  = 8'h62;
  localparam logic [7:0]  TCSIRQ_WAVE_ONLY     = 8'h0c;
  localparam logic [7:0]  TCSIRQ_FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  TCSIRQ_MASK_RESET    = 8'h00;
  localparam logic [31:0] TCSIRQ_RDATA_RESET   = 32'h0000_0000;
endpackage

// *** hdl/tcsirq_sticky_flags.sv ***
module tcsirq_sticky_flags
  import tcsirq_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic [TCSIRQ_NUM_SRC-1:0] set_in,
  input  wire logic                      clear_in,
  output logic      [TCSIRQ_NUM_SRC-1:0] flags_out,
  output logic      [TCSIRQ_NUM_SRC-1:0] next_flags_out
);
  logic [TCSIRQ_NUM_SRC-1:0] flags;
  logic [TCSIRQ_NUM_SRC-1:0] next_flags;

  // Set beats the read-clear in the same cycle
  for (genvar i = 0; i < TCSIRQ_NUM_SRC; i++) begin : g_flag
    always_comb begin
      next_flags[i] = set_in[i] | (flags[i] & ~clear_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags <= TCSIRQ_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign flags_out      = flags;
  assign next_flags_out = next_flags;
endmodule

// *** test/tb.sv ***
module tb;
  import tcsirq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
  logic        clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic        wave = 0, clk_on = 0, pa = 0, pb = 0, irq_out;
  logic [1:0]  crd = 0;
  logic [3:0]  lines = 0;
  logic [6:0]  evt = 0;
  logic [7:0]  addr_in = 0, flags = 0, mask = 0, ev;
  logic [31:0] wdata_in = 0, rdata_out, exp_rd = 0;
  int          error_cnt = 0, cmp_count = 0;
  always #4 clk_in = ~clk_in;
  tcsirq_channel u_tcsirq_channel (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .wave_mode_in(wave), .overflow_evt_in(evt[0]), .compare_a_evt_in(evt[1]),
    .compare_b_evt_in(evt[2]), .compare_c_evt_in(evt[3]), .load_a_evt_in(evt[4]),
    .load_b_evt_in(evt[5]), .capture_a_read_in(crd[0]), .capture_b_read_in(crd[1]),
    .ext_trigger_evt_in(evt[6]), .counter_clock_on_in(clk_on),
    .timer_line_a_pin_in(lines[0]), .timer_line_a_drive_in(lines[1]),
    .timer_line_b_pin_in(lines[2]), .timer_line_b_drive_in(lines[3]), .irq_out);
  // Reference model, updated with the inputs of the cycle that just ended
  always @(posedge clk_in) begin
    ev = {evt[6], evt[5:4] & {2{!wave}}, evt[3], evt[2:1] & {2{wave}},
      !wave && (evt[4] && pa || evt[5] && pb), evt[0]};
    exp_rd = 32'h0;
    if (rd_in && addr_in == TCSIRQ_OFF_STATUS) begin
      exp_rd = {13'h0, lines[{1'b1, wave}], lines[{1'b0, wave}], clk_on, 8'h0, flags};
      flags = 8'h0;
    end
    if (rd_in && addr_in == TCSIRQ_OFF_MASK_VIEW) exp_rd = {24'h0, mask};
    if (wr_in && addr_in == TCSIRQ_OFF_EN_SET) mask = mask | wdata_in[7:0];
    if (wr_in && addr_in == TCSIRQ_OFF_EN_CLEAR)
      mask = mask & ~(wdata_in[7:0] & (wave ? 8'h9d : 8'hf3));
    flags = flags | ev;
    pa = !wave && (evt[4] || pa && !crd[0]);
    pb = !wave && (evt[5] || pb && !crd[1]);
    if (rst_in) begin
      {flags, mask, pa, pb, exp_rd} = '0;
    end
  end
  always @(negedge clk_in) begin
    if (!rst_in) begin
      `CHK("rdata_out", exp_rd, rdata_out)
      `CHK("irq_out", |(flags & mask), irq_out)
    end
  end
  task automatic run(string name, int n, int k);
    logic [7:0] e;
    int         op;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      e = 8'($urandom);
      repeat (k) e &= 8'($urandom);
      op = $urandom % 4;
      evt <= e[6:0];
      crd <= 2'($urandom) & ~e[5:4];
      rd_in <= op == 1;
      wr_in <= op == 2;
      addr_in <= 8'($urandom % 5) << 2;
      wdata_in <= $urandom;
      lines <= 4'($urandom);
      clk_on <= 1'($urandom);
      if ($urandom % 64 == 0) wave <= !wave;
    end
    // Strobes and event pulses end here, so none is held through a reset or idle gap
    @(posedge clk_in);
    {evt, crd, rd_in, wr_in} <= '0;
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(38912));
    repeat (8) @(posedge clk_in);
    rst_in <= 0;
    run("dense", 3000, 1);
    run("sparse", 3000, 3);
    @(posedge clk_in) rst_in <= 1;
    @(posedge clk_in) rst_in <= 0;
    run("after_reset", 2000, 2);
    final_report;
  end
endmodule
bind tcsirq_channel tcsirq_chk u_chk (.*);

// *** test/tcsirq_chk.sv ***
module tcsirq_chk
  import tcsirq_pkg::*;
(
  input logic        clk_in,
  input logic        rst_in,
  input logic [7:0]  addr_in,
  input logic [31:0] wdata_in,
  input logic        wr_in,
  input logic        rd_in,
  input logic [31:0] rdata_out,
  input logic        wave_mode_in,
  input logic        overflow_evt_in,
  input logic        compare_a_evt_in,
  input logic        compare_b_evt_in,
  input logic        compare_c_evt_in,
  input logic        load_a_evt_in,
  input logic        load_b_evt_in,
  input logic        ext_trigger_evt_in,
  input logic        counter_clock_on_in,
  input logic        timer_line_a_pin_in,
  input logic        timer_line_a_drive_in,
  input logic        timer_line_b_pin_in,
  input logic        timer_line_b_drive_in,
  input logic        irq_out
);
  wire st_rd = rd_in && addr_in == TCSIRQ_OFF_STATUS;
  wire mir_a = wave_mode_in ? timer_line_a_drive_in : timer_line_a_pin_in;
  wire mir_b = wave_mode_in ? timer_line_b_drive_in : timer_line_b_pin_in;
  wire any_ev = overflow_evt_in | compare_a_evt_in | compare_b_evt_in | compare_c_evt_in
    | load_a_evt_in | load_b_evt_in | ext_trigger_evt_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  trig_flag_a:
    assert property (ext_trigger_evt_in ##1 st_rd |=> rdata_out[7]) else $error("trig flag");
  clk_mirror_a:
    assert property (st_rd |=> rdata_out[16] == $past(counter_clock_on_in)) else $error("clk");
  line_a_a:
    assert property (st_rd |=> rdata_out[17] == $past(mir_a)) else $error("line a");
  line_b_a:
    assert property (st_rd |=> rdata_out[18] == $past(mir_b)) else $error("line b");
  irq_raise_a:
    assert property (wr_in && addr_in == TCSIRQ_OFF_EN_SET && wdata_in[0]
      ##1 overflow_evt_in && !wr_in |=> irq_out) else $error("irq rise");
  mask_clr_a:
    assert property (wr_in && addr_in == TCSIRQ_OFF_EN_CLEAR && wdata_in[0]
      ##1 rd_in && addr_in == TCSIRQ_OFF_MASK_VIEW |=> !rdata_out[0]) else $error("mask");
  irq_drop_a:
    assert property (st_rd && !any_ev |=> !irq_out) else $error("irq drop");
  status_zero_a:
    assert property (st_rd |=> rdata_out[31:19] == 0 && rdata_out[15:8] == 0)
      else $error("reserved bits");
  cover property (st_rd ##1 rdata_out[1]);
  cover property ($rose(irq_out));
  cover property (wr_in && addr_in == TCSIRQ_OFF_EN_CLEAR && wave_mode_in);
endmodule
